/* File: hdl/phy_diag_pkg.sv */
// Constants, field positions and carrier types of the test, diagnostic
// and reset register group of a 10/100 transceiver.
// Assumes a 5-bit management register address and 16-bit register data.
package phy_diag_pkg;

    // Bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [4:0] OFF_TENBASE = 5'h1a;
    localparam logic [4:0] OFF_SELFTEST_GAP = 5'h1b;
    localparam logic [4:0] OFF_SELFTEST_LEN = 5'h1c;
    localparam logic [4:0] OFF_CABLE = 5'h1e;
    localparam logic [4:0] OFF_RESET = 5'h1f;
    localparam logic [4:0] OFF_IRQ_STATUS = 5'h14;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h15;
    localparam logic [4:0] OFF_DIAG_CFG = 5'h17;

    // Field positions
    localparam int TB_LOWTH_BIT = 13;
    localparam int TB_SQ_LSB = 9;
    localparam int TB_RSV_BIT = 8;
    localparam int TB_NLP_BIT = 7;
    localparam int TB_POL_BIT = 4;
    localparam int TB_JAB_BIT = 0;
    localparam int SG_CAPTURE_BIT = 15;
    localparam int CD_START_BIT = 15;
    localparam int RC_SWRST_BIT = 15;
    localparam int RC_DIGRST_BIT = 14;
    localparam int CFG_WRAP_BIT = 0;

    // Reset values and fixed read values
    localparam logic [7:0] IPG_RST = 8'h7d;
    localparam logic [10:0] PKTLEN_RST = 11'h5ee;
    localparam logic [3:0] SQUELCH_RST = 4'h0;
    localparam logic DONE_RST = 1'b1;
    localparam logic [12:0] CD_RSV_VAL = 13'h0040;
    localparam logic [7:0] CNT_MAX = 8'hff;

    // Interrupt status and mask layout
    localparam int IRQ_W = 4;
    localparam int IRQ_POL = 0;
    localparam int IRQ_CDDONE = 1;
    localparam int IRQ_CDFAIL = 2;
    localparam int IRQ_CNTMAX = 3;

    // Settings that steer the 10BASE-Te receiver and transmitter
    typedef struct packed {
        logic lowThresh;
        logic [3:0] squelch;
        logic nlpDisable;
        logic jabberDisable;
    } tenbase_cfg_s;

    // Settings of the self-test packet generator
    typedef struct packed {
        logic [7:0] ipgLength;
        logic [10:0] pktLength;
    } selftest_cfg_s;

endpackage

/* File: hdl/phy_test_diag_reset_regs.sv */
// Test, diagnostic and reset management registers of a 10/100 PHY.
// Assumes all event and status inputs come from logic on sys_clk and
// that the bus master keeps read and write strobes one cycle long.
//
// Operation
// - Lower threshold bit selects reduced receiver threshold
// - Four-bit squelch code sets on-threshold level
// - Link-pulse disable bit stops normal link pulses
// - Polarity bit reports inverted receive polarity
// - Reading status/control clears both polarity copies
// - Jabber disable bit turns jabber protection off
// - Eight-bit counter of errored self-test bytes
// - Writing capture bit locks count, clears counter
// - Counter saturates at maximum in mode zero
// - Eight-bit gap between generated packets, resets 0x7D
// - Eleven-bit generated packet length, resets 0x5EE
// - Start bit begins cable measurement, zero disables
// - Start bit clears when done is raised
// - Done bit shows completion, resets to one
// - Fail bit shows failed cable measurement
// - Software reset bit resets all but read data, self-clears
// - Digital restart resets logic, keeps registers
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps

module phy_test_diag_reset_regs (
    input wire logic sys_clk, // System clock, 200 MHz
    input wire logic arst_n, // Async reset, low active
    input wire logic clkEn, // Freezes all state when low
    input wire logic [phy_diag_pkg::ADDR_W-1:0] regAddr, // Register addr
    input wire logic [phy_diag_pkg::DATA_W-1:0] regWrData, // Write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    output logic [phy_diag_pkg::DATA_W-1:0] regRdData, // Read data
    input wire logic polInverted, // Inverted polarity seen
    output logic polStatusMirror, // Copy for the PHY status reg
    input wire logic prbsErrByte, // One errored byte this cycle
    input wire logic cableDoneEvt, // Measurement finished pulse
    input wire logic cableFailed, // Result qualifier of done
    output logic cableStart, // Measurement running request
    output phy_diag_pkg::tenbase_cfg_s tenbaseCfg, // 10BASE-Te settings
    output phy_diag_pkg::selftest_cfg_s selftestCfg, // Generator setup
    output logic swResetOut, // Whole-PHY reset pulse
    output logic digRestartOut, // Digital restart pulse
    output logic irq // Level interrupt
);
    import phy_diag_pkg::*;

    // Address match, shared by write and read decode
    function automatic logic hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] off
    );
        hit = (addr == off);
    endfunction

    // State
    tenbase_cfg_s tbCfg_reg;
    tenbase_cfg_s tbCfg_next;
    logic tbRsv_reg;
    logic tbRsv_next;
    logic pol_reg;
    logic pol_next;
    logic [7:0] errCnt_reg;
    logic [7:0] errCnt_next;
    logic [7:0] locked_reg;
    logic [7:0] locked_next;
    selftest_cfg_s stCfg_reg;
    selftest_cfg_s stCfg_next;
    logic start_reg;
    logic start_next;
    logic done_reg;
    logic done_next;
    logic fail_reg;
    logic fail_next;
    logic [13:0] rcRsv_reg;
    logic [13:0] rcRsv_next;
    logic swRst_reg;
    logic swRst_next;
    logic digRst_reg;
    logic digRst_next;
    logic wrap_reg;
    logic wrap_next;
    logic [IRQ_W-1:0] status_reg;
    logic [IRQ_W-1:0] status_next;
    logic [IRQ_W-1:0] mask_reg;
    logic [IRQ_W-1:0] mask_next;
    logic irq_reg;
    logic irq_next;
    logic [DATA_W-1:0] rdData_reg;
    logic [DATA_W-1:0] rdData_next;

    // Decode
    logic softClr;
    logic wrTenbase;
    logic wrGap;
    logic wrLen;
    logic wrCable;
    logic wrReset;
    logic wrIrqStat;
    logic wrIrqMask;
    logic wrCfg;
    logic rdTenbase;
    logic captureReq;
    logic startWr;
    logic doneAccept;
    logic cntSat;
    logic cntHitMax;
    logic [7:0] cntInc;
    logic [IRQ_W-1:0] evt;
    logic [DATA_W-1:0] valTenbase;
    logic [DATA_W-1:0] valGap;
    logic [DATA_W-1:0] valLen;
    logic [DATA_W-1:0] valCable;
    logic [DATA_W-1:0] valReset;
    logic [DATA_W-1:0] valIrqStat;
    logic [DATA_W-1:0] valIrqMask;
    logic [DATA_W-1:0] valCfg;
    logic [DATA_W-1:0] rdSel;

    // A software reset takes effect one cycle after its write, so every
    // register except rdData_reg, which still loads a read strobed in that cycle, returns to its reset value exactly as under the pin
    assign softClr = swRst_reg;

    // Write decode; strobes are one cycle so each write acts once
    assign wrTenbase = regWr & hit(regAddr, OFF_TENBASE);
    assign wrGap = regWr & hit(regAddr, OFF_SELFTEST_GAP);
    assign wrLen = regWr & hit(regAddr, OFF_SELFTEST_LEN);
    assign wrCable = regWr & hit(regAddr, OFF_CABLE);
    assign wrReset = regWr & hit(regAddr, OFF_RESET);
    assign wrIrqStat = regWr & hit(regAddr, OFF_IRQ_STATUS);
    assign wrIrqMask = regWr & hit(regAddr, OFF_IRQ_MASK);
    assign wrCfg = regWr & hit(regAddr, OFF_DIAG_CFG);
    assign rdTenbase = regRd & hit(regAddr, OFF_TENBASE);

    // 10BASE-Te settings; each field drives the receiver or transmitter
    assign tbCfg_next.lowThresh = softClr ? 1'b0 :
        wrTenbase ? regWrData[TB_LOWTH_BIT] :
        tbCfg_reg.lowThresh;
    assign tbCfg_next.squelch = softClr ? SQUELCH_RST :
        wrTenbase ? regWrData[TB_SQ_LSB +: 4] :
        tbCfg_reg.squelch;
    assign tbCfg_next.nlpDisable = softClr ? 1'b0 :
        wrTenbase ? regWrData[TB_NLP_BIT] :
        tbCfg_reg.nlpDisable;
    // Only the 10BASE-Te path looks at the jabber disable
    assign tbCfg_next.jabberDisable = softClr ? 1'b0 :
        wrTenbase ? regWrData[TB_JAB_BIT] :
        tbCfg_reg.jabberDisable;
    assign tbRsv_next = softClr ? 1'b0 :
        wrTenbase ? regWrData[TB_RSV_BIT] : tbRsv_reg;

    // Polarity flag: a detection in the clearing read cycle wins, so an
    // inversion seen during the read is still reported afterwards
    assign pol_next = softClr ? 1'b0 :
        polInverted ? 1'b1 :
        rdTenbase ? 1'b0 : pol_reg;

    // Error counter, saturating unless wrap mode is selected
    assign captureReq = wrGap & regWrData[SG_CAPTURE_BIT];
    assign cntSat = (errCnt_reg == CNT_MAX);
    assign cntInc = (wrap_reg | ~cntSat) ?
        8'(errCnt_reg + 8'h01) : errCnt_reg;
    assign cntHitMax = prbsErrByte & ~captureReq &
        (errCnt_reg == 8'(CNT_MAX - 8'h01));
    // An error byte arriving with the capture counts in the fresh run
    assign errCnt_next = softClr ? 8'h00 :
        captureReq ? {7'h00, prbsErrByte} :
        prbsErrByte ? cntInc : errCnt_reg;
    // Reads show the value locked at the last capture
    assign locked_next = softClr ? 8'h00 :
        captureReq ? errCnt_reg : locked_reg;

    // Generator setup
    assign stCfg_next.ipgLength = softClr ? IPG_RST :
        wrGap ? regWrData[7:0] : stCfg_reg.ipgLength;
    assign stCfg_next.pktLength = softClr ? PKTLEN_RST :
        wrLen ? regWrData[10:0] : stCfg_reg.pktLength;

    // Cable diagnostics; a fresh start written in the same cycle as a
    // done pulse wins, since that pulse belongs to the finished run
    assign startWr = wrCable & regWrData[CD_START_BIT];
    assign doneAccept = cableDoneEvt & start_reg & ~startWr;
    assign start_next = softClr ? 1'b0 :
        wrCable ? regWrData[CD_START_BIT] :
        doneAccept ? 1'b0 : start_reg;
    assign done_next = softClr ? DONE_RST :
        startWr ? 1'b0 :
        doneAccept ? 1'b1 : done_reg;
    assign fail_next = softClr ? 1'b0 :
        startWr ? 1'b0 :
        doneAccept ? cableFailed : fail_reg;

    // Reset control; the action bits exist only as one-cycle pulses
    assign rcRsv_next = softClr ? 14'h0000 :
        wrReset ? regWrData[13:0] : rcRsv_reg;
    assign swRst_next = ~softClr & wrReset &
        regWrData[RC_SWRST_BIT];
    // Digital restart leaves every register here untouched
    assign digRst_next = ~softClr & wrReset &
        regWrData[RC_DIGRST_BIT];

    // Counter mode selection
    assign wrap_next = softClr ? 1'b0 :
        wrCfg ? regWrData[CFG_WRAP_BIT] : wrap_reg;

    // Interrupt events
    assign evt[IRQ_POL] = polInverted & ~pol_reg;
    assign evt[IRQ_CDDONE] = doneAccept;
    assign evt[IRQ_CDFAIL] = doneAccept & cableFailed;
    assign evt[IRQ_CNTMAX] = cntHitMax & ~wrap_reg;

    // Sticky status, write one to clear; a new event beats the clear
    genvar gi;
    generate
        for (gi = 0; gi < IRQ_W; gi = gi + 1) begin : gStat
            assign status_next[gi] = ~softClr & (evt[gi] |
                (status_reg[gi] & ~(wrIrqStat & regWrData[gi])));
        end
    endgenerate
    assign mask_next = softClr ? {IRQ_W{1'b0}} :
        wrIrqMask ? regWrData[IRQ_W-1:0] : mask_reg;
    // Registered from next values so the pin tracks status with no lag
    assign irq_next = |(status_next & mask_next);

    // Read values; unused bits read as their fixed contents, reserved tbRsv_reg and rcRsv_reg read back as written
    assign valTenbase = {2'b00, tbCfg_reg.lowThresh,
        tbCfg_reg.squelch, tbRsv_reg, tbCfg_reg.nlpDisable,
        2'b00, pol_reg, 3'b000, tbCfg_reg.jabberDisable};
    // The capture bit position reads bit 7 of the count locked at the last capture
    assign valGap = {locked_reg, stCfg_reg.ipgLength};
    assign valLen = {5'h00, stCfg_reg.pktLength};
    assign valCable = {start_reg, CD_RSV_VAL, done_reg, fail_reg};
    assign valReset = {2'b00, rcRsv_reg};
    assign valIrqStat = {{(DATA_W-IRQ_W){1'b0}}, status_reg};
    assign valIrqMask = {{(DATA_W-IRQ_W){1'b0}}, mask_reg};
    assign valCfg = {15'h0000, wrap_reg};

    // Read selection; unmapped addresses read zero
    assign rdSel = hit(regAddr, OFF_TENBASE) ? valTenbase :
        hit(regAddr, OFF_SELFTEST_GAP) ? valGap :
        hit(regAddr, OFF_SELFTEST_LEN) ? valLen :
        hit(regAddr, OFF_CABLE) ? valCable :
        hit(regAddr, OFF_RESET) ? valReset :
        hit(regAddr, OFF_IRQ_STATUS) ? valIrqStat :
        hit(regAddr, OFF_IRQ_MASK) ? valIrqMask :
        hit(regAddr, OFF_DIAG_CFG) ? valCfg :
        16'h0000;
    // Data stand for the single cycle after the strobe only
    assign rdData_next = regRd ? rdSel : 16'h0000;

    // 10BASE-Te and polarity state
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tbCfg_reg <= '0;
            tbRsv_reg <= 1'b0;
            pol_reg <= 1'b0;
        end else if (clkEn) begin
            tbCfg_reg <= tbCfg_next;
            tbRsv_reg <= tbRsv_next;
            pol_reg <= pol_next;
        end
    end

    // Self-test counter and generator setup
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            errCnt_reg <= 8'h00;
            locked_reg <= 8'h00;
            stCfg_reg <= {IPG_RST, PKTLEN_RST};
            wrap_reg <= 1'b0;
        end else if (clkEn) begin
            errCnt_reg <= errCnt_next;
            locked_reg <= locked_next;
            stCfg_reg <= stCfg_next;
            wrap_reg <= wrap_next;
        end
    end

    // Cable diagnostic state
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            start_reg <= 1'b0;
            done_reg <= DONE_RST;
            fail_reg <= 1'b0;
        end else if (clkEn) begin
            start_reg <= start_next;
            done_reg <= done_next;
            fail_reg <= fail_next;
        end
    end

    // Reset control state
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rcRsv_reg <= 14'h0000;
            swRst_reg <= 1'b0;
            digRst_reg <= 1'b0;
        end else if (clkEn) begin
            rcRsv_reg <= rcRsv_next;
            swRst_reg <= swRst_next;
            digRst_reg <= digRst_next;
        end
    end

    // Interrupt state
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_reg <= {IRQ_W{1'b0}};
            mask_reg <= {IRQ_W{1'b0}};
            irq_reg <= 1'b0;
        end else if (clkEn) begin
            status_reg <= status_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
        end
    end

    // Read data register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdData_reg <= 16'h0000;
        end else if (clkEn) begin
            rdData_reg <= rdData_next;
        end
    end

    // Outputs, each straight from a flip-flop
    assign regRdData = rdData_reg;
    assign polStatusMirror = pol_reg;
    assign cableStart = start_reg;
    assign tenbaseCfg = tbCfg_reg;
    assign selftestCfg = stCfg_reg;
    assign swResetOut = swRst_reg;
    assign digRestartOut = digRst_reg;
    assign irq = irq_reg;

endmodule

/* File: verif/phy_test_diag_reset_regs_sva.sv */
// Port-level checks of the test, diagnostic and reset register group.
// Assumes one sys_clk domain with asynchronous active-low arst_n.
`timescale 1ns/1ps
module phy_test_diag_reset_regs_sva (
    input wire logic sys_clk, // Clock
    input wire logic arst_n, // Async reset
    input wire logic clkEn, // Clock enable
    input wire logic [phy_diag_pkg::ADDR_W-1:0] regAddr, // Address
    input wire logic [phy_diag_pkg::DATA_W-1:0] regWrData, // Write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    input wire logic [phy_diag_pkg::DATA_W-1:0] regRdData, // Read data
    input wire logic polInverted, // Polarity seen
    input wire logic polStatusMirror, // Sticky polarity
    input wire logic cableDoneEvt, // Done pulse
    input wire logic cableStart, // Start bit
    input wire phy_diag_pkg::selftest_cfg_s selftestCfg, // Generator
    input wire logic swResetOut, // Reset pulse
    input wire logic digRestartOut // Restart pulse
);
    import phy_diag_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    // Writes in the software reset cycle are lost, so they do not count
    wire wrTaken = regWr && clkEn && !swResetOut;
    wire rdTen = regRd && clkEn && regAddr == OFF_TENBASE;
    sequence swWrite;
        wrTaken && regAddr == OFF_RESET && regWrData[RC_SWRST_BIT];
    endsequence
    sequence drWrite;
        wrTaken && regAddr == OFF_RESET && regWrData[RC_DIGRST_BIT];
    endsequence
    sequence onePulse(sig);
        sig ##1 !sig;
    endsequence
    sw_reset_pulse_a: assert property (
        swWrite |=> onePulse(swResetOut))
        else $error("software reset pulse wrong");
    sw_reset_clear_a: assert property (
        swResetOut |=> !cableStart &&
        selftestCfg.pktLength == PKTLEN_RST &&
        selftestCfg.ipgLength == IPG_RST)
        else $error("software reset left state");
    dig_restart_a: assert property (
        drWrite |=> onePulse(digRestartOut))
        else $error("digital restart pulse wrong");
    // A restart on its own must leave the generator setup (selftestCfg) as it was
    dig_keep_regs_a: assert property (
        digRestartOut && !swResetOut && !(regWr && clkEn) |=>
        $stable(selftestCfg))
        else $error("digital restart changed registers");
    cable_start_a: assert property (
        wrTaken && regAddr == OFF_CABLE &&
        regWrData[CD_START_BIT] |=> cableStart)
        else $error("start write not taken");
    cable_rise_a: assert property (
        $rose(cableStart) |->
        $past(regWr) && $past(regAddr) == OFF_CABLE)
        else $error("start rose without write");
    cable_done_a: assert property (
        cableStart && cableDoneEvt && clkEn &&
        !(wrTaken && regAddr == OFF_CABLE) |=> !cableStart)
        else $error("start not cleared by done");
    pol_set_a: assert property (
        polInverted && clkEn && !swResetOut |=> polStatusMirror)
        else $error("polarity not flagged");
    pol_hold_a: assert property (
        polStatusMirror && !swResetOut && !rdTen |=> polStatusMirror)
        else $error("polarity flag lost");
    pol_read_a: assert property (
        rdTen |=> regRdData[TB_POL_BIT] == $past(polStatusMirror))
        else $error("polarity read value wrong");
    pol_clear_a: assert property (
        rdTen && !polInverted |=> !polStatusMirror)
        else $error("polarity not cleared by read");
    sc_read_zero_a: assert property (
        regRd && clkEn && regAddr == OFF_RESET |=>
        regRdData[15:14] == 2'h0)
        else $error("self-clearing bits read one");
endmodule

/* File: verif/phy_test_diag_reset_regs_tb.sv */
// Self-checking bench of the test, diagnostic and reset register group.
// Assumes the design package is compiled first; clkEn stays high except
// in the freeze test.
`timescale 1ns/1ps
module phy_test_diag_reset_regs_tb;
    import phy_diag_pkg::*;
    logic sys_clk = 1'h0;
    logic arst_n = 1'h0;
    logic clkEn = 1'h1;
    logic regWr = 1'h0;
    logic regRd = 1'h0;
    logic polInverted = 1'h0;
    logic prbsErrByte = 1'h0;
    logic cableDoneEvt = 1'h0;
    logic cableFailed = 1'h0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0;
    logic [DATA_W-1:0] regRdData;
    logic polStatusMirror, cableStart, swResetOut, digRestartOut, irq;
    tenbase_cfg_s tenbaseCfg;
    selftest_cfg_s selftestCfg;
    int n_mismatch = 0;
    int compares = 0;
    int nSw = 0;
    int nDig = 0;
    always #2.5 sys_clk = ~sys_clk;
    phy_test_diag_reset_regs dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .polInverted(polInverted), .polStatusMirror(polStatusMirror),
        .prbsErrByte(prbsErrByte), .cableDoneEvt(cableDoneEvt),
        .cableFailed(cableFailed), .cableStart(cableStart),
        .tenbaseCfg(tenbaseCfg), .selftestCfg(selftestCfg),
        .swResetOut(swResetOut), .digRestartOut(digRestartOut), .irq(irq));
    // Pulse counters; one-cycle pulses must add exactly one each. Taken
    // at the falling edge, where the outputs have settled
    always @(negedge sys_clk) begin
        if (swResetOut === 1'h1) nSw++;
        if (digRestartOut === 1'h1) nDig++;
    end
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Tasks start and end on a rising edge; checks made there see the
    // state settled by the edge before, so no launch race arises
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'h1;
        @(posedge sys_clk);
        regWr <= 1'h0;
        @(posedge sys_clk);
    endtask
    // Read data stand in the cycle after the strobe edge only
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge sys_clk);
        regRd <= 1'h0;
        @(posedge sys_clk);
        chk($sformatf("reg %h", a), regRdData, exp);
    endtask
    // One-hot select: bit 0 polarity, bit 1 error byte, bit 2 cable done
    task automatic pulse(input logic [2:0] sel, input int n);
        {cableDoneEvt, prbsErrByte, polInverted} <= sel;
        repeat (n) @(posedge sys_clk);
        {cableDoneEvt, prbsErrByte, polInverted} <= 3'h0;
        @(posedge sys_clk);
    endtask
    task automatic t_defaults();
        rd(OFF_TENBASE, 16'h0000);
        rd(OFF_SELFTEST_GAP, 16'h007d);
        rd(OFF_SELFTEST_LEN, 16'h05ee);
        rd(OFF_CABLE, 16'h0102);
        rd(OFF_RESET, 16'h0000);
        rd(5'h05, 16'h0000);
        $display("test defaults done");
    endtask
    task automatic t_tenbase();
        for (int i = 0; i < 16; i++) begin
            wr(OFF_TENBASE, 16'(i) << TB_SQ_LSB);
            chk("squelch", 16'(tenbaseCfg.squelch), 16'(i));
        end
        wr(OFF_TENBASE, 16'hffff);
        chk("tenCfg", 16'(tenbaseCfg), 16'h007f);
        rd(OFF_TENBASE, 16'h3f81);
        wr(OFF_TENBASE, 16'h0081);
        chk("tenCfg", 16'(tenbaseCfg), 16'h0003);
        wr(OFF_TENBASE, 16'h0000);
        $display("test tenbase done");
    endtask
    // A write while the enable is low must leave every register alone
    task automatic t_freeze();
        clkEn <= 1'h0;
        wr(OFF_TENBASE, 16'h2000);
        chk("frozenCfg", 16'(tenbaseCfg), 16'h0000);
        clkEn <= 1'h1;
        rd(OFF_TENBASE, 16'h0000);
        $display("test freeze done");
    endtask
    task automatic t_polarity();
        wr(OFF_IRQ_MASK, 16'h0001);
        pulse(3'h1, 1);
        chk("polMirror", 16'(polStatusMirror), 16'h0001);
        chk("irq", 16'(irq), 16'h0001);
        rd(OFF_TENBASE, 16'h0010);
        chk("polMirror", 16'(polStatusMirror), 16'h0000);
        rd(OFF_TENBASE, 16'h0000);
        wr(OFF_IRQ_STATUS, 16'h0001);
        chk("irq", 16'(irq), 16'h0000);
        $display("test polarity done");
    endtask
    task automatic t_counter();
        pulse(3'h2, 5);
        wr(OFF_SELFTEST_GAP, 16'h8011);
        chk("ipg", 16'(selftestCfg.ipgLength), 16'h0011);
        rd(OFF_SELFTEST_GAP, 16'h0511);
        wr(OFF_SELFTEST_GAP, 16'h807d);
        rd(OFF_SELFTEST_GAP, 16'h007d);
        wr(OFF_IRQ_MASK, 16'h0008);
        pulse(3'h2, 300);
        chk("irq", 16'(irq), 16'h0001);
        wr(OFF_SELFTEST_GAP, 16'h807d);
        rd(OFF_SELFTEST_GAP, 16'hff7d);
        wr(OFF_IRQ_STATUS, 16'h0008);
        wr(OFF_DIAG_CFG, 16'h0001);
        pulse(3'h2, 260);
        wr(OFF_SELFTEST_GAP, 16'h807d);
        rd(OFF_SELFTEST_GAP, 16'h047d);
        wr(OFF_DIAG_CFG, 16'h0000);
        wr(OFF_SELFTEST_LEN, 16'hffff);
        rd(OFF_SELFTEST_LEN, 16'h07ff);
        $display("test counter done");
    endtask
    task automatic t_cable();
        wr(OFF_IRQ_MASK, 16'h0006);
        wr(OFF_CABLE, 16'h8000);
        rd(OFF_CABLE, 16'h8100);
        cableFailed <= 1'h1;
        pulse(3'h4, 1);
        chk("start", 16'(cableStart), 16'h0000);
        chk("irq", 16'(irq), 16'h0001);
        rd(OFF_CABLE, 16'h0103);
        cableFailed <= 1'h0;
        wr(OFF_CABLE, 16'h8000);
        pulse(3'h4, 1);
        rd(OFF_CABLE, 16'h0102);
        wr(OFF_CABLE, 16'h8000);
        wr(OFF_CABLE, 16'h0000);
        pulse(3'h4, 1);
        rd(OFF_CABLE, 16'h0100);
        wr(OFF_IRQ_STATUS, 16'h0006);
        chk("irq", 16'(irq), 16'h0000);
        $display("test cable done");
    endtask
    task automatic t_resets();
        wr(OFF_SELFTEST_LEN, 16'h0123);
        wr(OFF_RESET, 16'h4000);
        chk("restarts", 16'(nDig), 16'h0001);
        rd(OFF_SELFTEST_LEN, 16'h0123);
        rd(OFF_RESET, 16'h0000);
        wr(OFF_RESET, 16'h0000);
        wr(OFF_TENBASE, 16'h2000);
        wr(OFF_RESET, 16'h8000);
        chk("swResets", 16'(nSw), 16'h0001);
        rd(OFF_TENBASE, 16'h0000);
        rd(OFF_SELFTEST_LEN, 16'h05ee);
        rd(OFF_RESET, 16'h0000);
        $display("test resets done");
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Whole run is under a thousand cycles; this limit only cuts a hang
    initial begin
        #100000;
        n_mismatch++;
        results();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'h1;
        t_defaults();
        t_tenbase();
        t_freeze();
        t_polarity();
        t_counter();
        t_cable();
        t_resets();
        results();
    end
endmodule
bind phy_test_diag_reset_regs phy_test_diag_reset_regs_sva checker_i (
    .sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .polInverted(polInverted),
    .polStatusMirror(polStatusMirror), .cableDoneEvt(cableDoneEvt),
    .cableStart(cableStart), .selftestCfg(selftestCfg),
    .swResetOut(swResetOut), .digRestartOut(digRestartOut));
